/* rmc_pkg.sv */
// Package of constants, types and decoders for the redriver mux control block.
`default_nettype none

package rmc_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Interval between two detection attempts on a pending channel.
  localparam int unsigned ATTEMPT_PERIOD_NS = 100000;
  localparam int unsigned ATTEMPT_CYCLES = (ATTEMPT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Width of the probe strobe sent to the analog detector at each attempt.
  localparam int unsigned PROBE_PULSE_NS = 1000;
  localparam int unsigned PROBE_CYCLES = (PROBE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ATTEMPT_CNT_W = 10;
  localparam logic [ATTEMPT_CNT_W-1:0] ATTEMPT_LAST = ATTEMPT_CNT_W'(ATTEMPT_CYCLES - 1);
  localparam logic [ATTEMPT_CNT_W-1:0] PROBE_LAST = ATTEMPT_CNT_W'(PROBE_CYCLES);

  // ***************************************************************
  // Further attempts after the first channel is found
  // ***************************************************************
  localparam int unsigned EXTRA_CNT_W = 17;
  localparam logic [EXTRA_CNT_W-1:0] EXTRA_LIMIT = 17'h10000;

  // ***************************************************************
  // Register map (byte addresses) and fields
  // ***************************************************************
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;
  localparam logic [ADDR_W-1:0] EXTRA_OFFSET = 4'h8;
  localparam logic [ADDR_W-1:0] SETTING_OFFSET = 4'hC;
  localparam int unsigned CTRL_RESTART_BIT = 0;
  localparam int unsigned CTRL_HOLD_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ***************************************************************
  // Types and decoders
  // ***************************************************************
  typedef enum logic [1:0] {ST_STANDBY, ST_DETECT, ST_ACTIVE} rmc_state_t;

  // Output de-emphasis: 0 = 0 dB low swing, 1 = 0 dB, 2 = 3.5 dB, 3 = 6 dB full swing.
  typedef enum logic [1:0] {DE_0DB_LOW, DE_0DB_FULL, DE_3P5DB, DE_6DB} rmc_deemph_t;
  // Input equalization: 0 dB, 3.5 dB or 6 dB boost.
  typedef enum logic [1:0] {EQ_0DB, EQ_3P5DB, EQ_6DB} rmc_eq_t;

  // Decodes the (msb, lsb) de-emphasis straps.
  function automatic rmc_deemph_t deemph_decode(input logic msb, input logic lsb);
    deemph_decode = rmc_deemph_t'({msb, lsb});
  endfunction : deemph_decode

  // Decodes the (msb, lsb) equalization straps; a low msb ignores the lsb.
  function automatic rmc_eq_t equalize_decode(input logic msb, input logic lsb);
    if (!msb) begin
      equalize_decode = EQ_0DB;
    end else if (!lsb) begin
      equalize_decode = EQ_3P5DB;
    end else begin
      equalize_decode = EQ_6DB;
    end
  endfunction : equalize_decode

endpackage : rmc_pkg

`default_nettype wire

/* rmc_sync.sv */
// Two-stage synchronizer for a group of asynchronous pin levels.
`timescale 1ns/10ps
`default_nettype none

module rmc_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Levels.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  // Both stages clear to low, matching an unconnected pulled-down pin.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage1_reg <= '0;
      sync_out <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end

endmodule : rmc_sync

`default_nettype wire

/* rmc_axil_slave.sv */
// AXI4-Lite slave front end that turns bus traffic into register strobes.
`timescale 1ns/10ps
`default_nettype none

module rmc_axil_slave
  import rmc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Write address and data channels.
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // Write response channel.
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // Read channels.
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Register side.
  output logic wr_en_out,
  output logic [ADDR_W-1:0] wr_addr_out,
  output logic [31:0] wr_data_out,
  output logic [3:0] wr_strb_out,
  input wire logic wr_err_in,
  output logic [ADDR_W-1:0] rd_addr_out,
  input wire logic [31:0] rd_data_in,
  input wire logic rd_err_in
);

  logic aw_held_reg;
  logic w_held_reg;
  wire aw_take = s_axi_awvalid_in & s_axi_awready_out;
  wire w_take = s_axi_wvalid_in & s_axi_wready_out;
  wire ar_take = s_axi_arvalid_in & s_axi_arready_out;

  // Each channel is taken once and held until the response is accepted.
  assign s_axi_awready_out = ~aw_held_reg & ~s_axi_bvalid_out;
  assign s_axi_wready_out = ~w_held_reg & ~s_axi_bvalid_out;
  assign s_axi_arready_out = ~s_axi_rvalid_out;
  assign rd_addr_out = s_axi_araddr_in;
  assign wr_en_out = aw_held_reg & w_held_reg & ~s_axi_bvalid_out;

  // Write path: capture address and data in either order, then respond.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wr_addr_out <= '0;
      wr_data_out <= '0;
      wr_strb_out <= '0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        wr_addr_out <= s_axi_awaddr_in;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wr_data_out <= s_axi_wdata_in;
        wr_strb_out <= s_axi_wstrb_in;
      end
      if (wr_en_out) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_err_in ? RESP_SLVERR : RESP_OKAY;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // Read path: data is captured with the address and returned next cycle.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= '0;
      s_axi_rresp_out <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= rd_data_in;
      s_axi_rresp_out <= rd_err_in ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

endmodule : rmc_axil_slave

`default_nettype wire

/* rmc_redriver_mux_control.sv */
// Top level of the redriver mux control: strap decode, receiver detection and idle gating.
//
// Operation
// - Enable low or floating holds standby: redrivers off, detection inactive.
// - Channel 1 output choice low routes to output A, high to output B.
// - Channel 2 input choice low takes input A, high takes input B.
// - De-emphasis 00 0 dB low swing, 01 0 dB, 10 3.5 dB, 11 6 dB.
// - Both de-emphasis bits low put that output in low-swing mode.
// - Equalization msb low gives 0 dB; 10 gives 3.5 dB; 11 gives 6 dB.
// - Detection starts on enable rising, or at power-up with enable high.
// - With enable high, any trigger or selector edge restarts detection.
// - During detection the device stays in standby with outputs squelched.
// - Detection retries without limit until a receiver is found on either channel.
// - After one channel is found, at most 2^16 more attempts on the other.
// - A detected channel gets its output driver and idle detection enabled.
// - With idle detection on, squelch below idle threshold, redrive above it.
// - Every control input reads low when left unconnected.
`timescale 1ns/10ps
`default_nettype none

module rmc_redriver_mux_control
  import rmc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Control pins.
  input wire logic enable_in,
  input wire logic ch1_output_choice_in,
  input wire logic ch2_input_choice_in,
  input wire logic detect_trigger_in,
  // De-emphasis straps.
  input wire logic ch1_out_a_deemph_msb_in,
  input wire logic ch1_out_a_deemph_lsb_in,
  input wire logic ch1_out_b_deemph_msb_in,
  input wire logic ch1_out_b_deemph_lsb_in,
  input wire logic ch2_out_deemph_msb_in,
  input wire logic ch2_out_deemph_lsb_in,
  // Equalization straps.
  input wire logic ch1_in_equalize_msb_in,
  input wire logic ch1_in_equalize_lsb_in,
  input wire logic ch2_in_a_equalize_msb_in,
  input wire logic ch2_in_a_equalize_lsb_in,
  input wire logic ch2_in_b_equalize_msb_in,
  input wire logic ch2_in_b_equalize_lsb_in,
  // Analog front end indications, bit 0 channel 1, bit 1 channel 2.
  input wire logic [1:0] receiver_present_in,
  input wire logic [1:0] above_idle_level_threshold_in,
  // Analog front end controls.
  output logic standby_out,
  output logic [1:0] probe_out,
  output logic [1:0] driver_enable_out,
  output logic [1:0] idle_detect_enable_out,
  output logic [1:0] squelch_out,
  output logic ch1_route_b_out,
  output logic ch2_source_b_out,
  // Decoded settings: index 0 ch1 out A, 1 ch1 out B, 2 ch2 out.
  output logic [5:0] deemph_code_out,
  output logic [2:0] low_swing_out,
  // Decoded settings: index 0 ch1 in, 1 ch2 in A, 2 ch2 in B.
  output logic [5:0] equalize_code_out,
  // AXI4-Lite register bus.
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);

  // ***************************************************************
  // Pin synchronization
  // ***************************************************************
  localparam int unsigned PIN_W = 20;
  logic [PIN_W-1:0] pins_sync;
  wire en_s = pins_sync[0];
  wire [3:0] ctl_s = pins_sync[3:0];
  wire [11:0] strap_s = pins_sync[15:4];
  wire [1:0] present_s = pins_sync[17:16];
  wire [1:0] active_s = pins_sync[19:18];

  rmc_sync #(
    .WIDTH(PIN_W)
  ) u_pin_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in({above_idle_level_threshold_in, receiver_present_in,
               ch2_in_b_equalize_msb_in, ch2_in_b_equalize_lsb_in,
               ch2_in_a_equalize_msb_in, ch2_in_a_equalize_lsb_in,
               ch1_in_equalize_msb_in, ch1_in_equalize_lsb_in,
               ch2_out_deemph_msb_in, ch2_out_deemph_lsb_in,
               ch1_out_b_deemph_msb_in, ch1_out_b_deemph_lsb_in,
               ch1_out_a_deemph_msb_in, ch1_out_a_deemph_lsb_in,
               detect_trigger_in, ch2_input_choice_in, ch1_output_choice_in, enable_in}),
    .sync_out(pins_sync)
  );

  // ***************************************************************
  // Register bus
  // ***************************************************************
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  logic wr_err;

  rmc_axil_slave u_bus (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .s_axi_awaddr_in(s_axi_awaddr_in),
    .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out),
    .s_axi_wdata_in(s_axi_wdata_in),
    .s_axi_wstrb_in(s_axi_wstrb_in),
    .s_axi_wvalid_in(s_axi_wvalid_in),
    .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bresp_out(s_axi_bresp_out),
    .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_bready_in(s_axi_bready_in),
    .s_axi_araddr_in(s_axi_araddr_in),
    .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rresp_out(s_axi_rresp_out),
    .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in),
    .wr_en_out(wr_en),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_strb_out(wr_strb),
    .wr_err_in(wr_err),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .rd_err_in(rd_err)
  );

  // Writes reach only the control word; a restart bit written as one is a pulse.
  wire ctrl_write = wr_en & (wr_addr == CTRL_OFFSET) & wr_strb[0];
  wire sw_restart = ctrl_write & wr_data[CTRL_RESTART_BIT];
  assign wr_err = (wr_addr != CTRL_OFFSET);
  logic hold_reg;

  // Software hold keeps detection from declaring the link active.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_reg <= CTRL_RESET[CTRL_HOLD_BIT];
    end else if (ctrl_write) begin
      hold_reg <= wr_data[CTRL_HOLD_BIT];
    end
  end

  // ***************************************************************
  // Restart detection
  // ***************************************************************
  logic [3:0] ctl_prev_reg;
  wire en_rise = en_s & ~ctl_prev_reg[0];
  wire ctl_edge = en_s & (|(ctl_s[3:1] ^ ctl_prev_reg[3:1]));
  wire restart = en_rise | ctl_edge | (en_s & sw_restart);

  // Previous levels reset low, so enable already high after reset reads as a rising edge.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctl_prev_reg <= 4'h0;
    end else begin
      ctl_prev_reg <= ctl_s;
    end
  end

  // ***************************************************************
  // Detection sequencer
  // ***************************************************************
  rmc_state_t state_reg;
  rmc_state_t state_next;
  logic [ATTEMPT_CNT_W-1:0] attempt_cnt_reg;
  logic [1:0] found_reg;
  logic [EXTRA_CNT_W-1:0] extra_cnt_reg;
  wire detecting = (state_reg == ST_DETECT);
  wire attempt_end = detecting & (attempt_cnt_reg == ATTEMPT_LAST);
  wire [1:0] pending = ~found_reg;
  wire [1:0] found_next = found_reg | (present_s & pending);
  wire one_found = found_reg[0] ^ found_reg[1];
  wire [EXTRA_CNT_W-1:0] extra_inc = extra_cnt_reg + 17'h00001;
  wire extra_done = one_found & (extra_inc == EXTRA_LIMIT);
  wire detect_done = attempt_end & ((found_next == 2'h3) | extra_done) & ~hold_reg;

  // Next state: enable low always wins, then a restart, then the sequence.
  always_comb begin
    state_next = state_reg;
    if (!en_s) begin
      state_next = ST_STANDBY;
    end else if (restart) begin
      state_next = ST_DETECT;
    end else if (detect_done) begin
      state_next = ST_ACTIVE;
    end
  end

  // Attempt timer, found flags and extra-attempt counter.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= ST_STANDBY;
      attempt_cnt_reg <= '0;
      found_reg <= 2'h0;
      extra_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (!en_s || restart) begin
        attempt_cnt_reg <= '0;
        found_reg <= 2'h0;
        extra_cnt_reg <= '0;
      end else if (detecting) begin
        attempt_cnt_reg <= attempt_end ? '0 : attempt_cnt_reg + 10'h001;
        if (attempt_end) begin
          found_reg <= found_next;
          if (one_found && !extra_done) begin
            extra_cnt_reg <= extra_inc;
          end
        end
      end
    end
  end

  // ***************************************************************
  // Analog control outputs
  // ***************************************************************
  wire active = (state_reg == ST_ACTIVE);
  wire [1:0] drive_next = active ? found_reg : 2'h0;
  wire [1:0] squelch_next = ~(drive_next & active_s);
  wire [1:0] probe_next = (detecting && attempt_cnt_reg < PROBE_LAST) ? pending : 2'h0;

  // Outputs are registered one cycle behind the sequencer.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      standby_out <= 1'b1;
      probe_out <= 2'h0;
      driver_enable_out <= 2'h0;
      idle_detect_enable_out <= 2'h0;
      squelch_out <= 2'h3;
      ch1_route_b_out <= 1'b0;
      ch2_source_b_out <= 1'b0;
    end else begin
      standby_out <= ~active;
      probe_out <= probe_next;
      driver_enable_out <= drive_next;
      idle_detect_enable_out <= drive_next;
      squelch_out <= squelch_next;
      ch1_route_b_out <= ctl_s[1];
      ch2_source_b_out <= ctl_s[2];
    end
  end

  // ***************************************************************
  // Strap decode
  // ***************************************************************
  logic [5:0] deemph_next;
  logic [5:0] equalize_next;
  logic [2:0] low_swing_next;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      deemph_next[2*i +: 2] = deemph_decode(strap_s[2*i+1], strap_s[2*i]);
      low_swing_next[i] = (deemph_decode(strap_s[2*i+1], strap_s[2*i]) == DE_0DB_LOW);
      equalize_next[2*i +: 2] = equalize_decode(strap_s[2*i+7], strap_s[2*i+6]);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      deemph_code_out <= 6'h00;
      low_swing_out <= 3'h7;
      equalize_code_out <= 6'h00;
    end else begin
      deemph_code_out <= deemph_next;
      low_swing_out <= low_swing_next;
      equalize_code_out <= equalize_next;
    end
  end

  // ***************************************************************
  // Read decode
  // ***************************************************************
  wire [31:0] ctrl_word = {30'h0, hold_reg, 1'b0};
  wire [31:0] status_word = {20'h0, present_s, ctl_s, found_reg, 2'h0, state_reg};
  wire [31:0] extra_word = {15'h0, extra_cnt_reg};
  wire [31:0] setting_word = {11'h0, low_swing_out, 6'h0, equalize_code_out, deemph_code_out};
  assign rd_err = ~(rd_addr inside {CTRL_OFFSET, STATUS_OFFSET, EXTRA_OFFSET, SETTING_OFFSET});
  assign rd_data = (rd_addr == CTRL_OFFSET) ? ctrl_word :
                   (rd_addr == STATUS_OFFSET) ? status_word :
                   (rd_addr == EXTRA_OFFSET) ? extra_word :
                   (rd_addr == SETTING_OFFSET) ? setting_word : 32'h0;

endmodule : rmc_redriver_mux_control

`default_nettype wire

/* rmc_checker.sv */
// Assertion checker bound to the redriver mux control top level.
`timescale 1ns/10ps
`default_nettype none
module rmc_checker (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Watched pins and outputs.
  input wire logic enable_in,
  input wire logic ch1_output_choice_in,
  input wire logic ch2_input_choice_in,
  input wire logic standby_out,
  input wire logic [1:0] probe_out,
  input wire logic [1:0] driver_enable_out,
  input wire logic [1:0] idle_detect_enable_out,
  input wire logic [1:0] squelch_out,
  input wire logic ch1_route_b_out,
  input wire logic ch2_source_b_out,
  input wire logic [5:0] deemph_code_out,
  input wire logic [2:0] low_swing_out,
  input wire logic [5:0] equalize_code_out
);
  // All checks share the one clock and rest while reset is low.
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  a_standby_when_off: assert property (!enable_in [*5] |-> standby_out && driver_enable_out == 2'h0)
    else $error("Outputs live with enable low.");
  a_ch1_route: assert property ($stable(ch1_output_choice_in) [*4] |-> ch1_route_b_out == ch1_output_choice_in)
    else $error("Channel 1 route wrong.");
  a_ch2_source: assert property ($stable(ch2_input_choice_in) [*4] |-> ch2_source_b_out == ch2_input_choice_in)
    else $error("Channel 2 source wrong.");
  a_low_swing_code: assert property (low_swing_out[0] == (deemph_code_out[1:0] == 2'h0))
    else $error("Low swing flag wrong.");
  a_eq_code_legal: assert property (equalize_code_out[1:0] != 2'h3 && equalize_code_out[5:4] != 2'h3)
    else $error("Equalization code illegal.");
  a_idle_with_driver: assert property (idle_detect_enable_out == driver_enable_out)
    else $error("Idle detection not with driver.");
  a_squelch_unless_on: assert property ((~squelch_out & ~driver_enable_out) == 2'h0)
    else $error("Unsquelched without driver.");
  a_quiet_probing: assert property (probe_out != 2'h0 |-> standby_out && squelch_out == 2'h3)
    else $error("Outputs live while probing.");
endmodule : rmc_checker
bind rmc_redriver_mux_control rmc_checker rmc_checker_inst (.*);
`default_nettype wire

/* rmc_link_partner.sv */
// Far-end link partners: receiver load after a probe and line activity.
`timescale 1ns/10ps
`default_nettype none
module rmc_link_partner (
  // Clock and scenario controls.
  input wire logic clk_in,
  input wire logic [1:0] att_in,
  input wire logic [1:0] send_in,
  input wire logic [7:0] delay_in,
  // Probe and analog indications.
  input wire logic [1:0] probe_in,
  output logic [1:0] present_out,
  output logic [1:0] above_out
);
  logic [7:0] age_reg [2] = '{8'hFF, 8'hFF};
  // A probe restarts the settling time of the load.
  always @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      age_reg[i] <= probe_in[i] ? 8'h00 : age_reg[i] + {7'h00, age_reg[i] != 8'hFF};
    end
  end
  // Only an attached partner shows a load or sends above the idle level.
  assign present_out = att_in & {age_reg[1] >= delay_in, age_reg[0] >= delay_in};
  assign above_out = att_in & send_in;
endmodule : rmc_link_partner
`default_nettype wire

/* rmc_redriver_mux_control_tb.sv */
// Self-checking testbench of the redriver mux control block.
`timescale 1ns/10ps
`default_nettype none
module rmc_redriver_mux_control_tb;
  // Pins, straps, partner controls and bus signals.
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic enable_in = 1'b0;
  logic ch1_output_choice_in = 1'b0;
  logic ch2_input_choice_in = 1'b0;
  logic detect_trigger_in = 1'b0;
  logic [11:0] st = 12'h000;
  logic [1:0] att = 2'h3;
  logic [1:0] snd = 2'h1;
  logic [7:0] dly = 8'h05;
  logic [1:0] receiver_present_in, above_idle_level_threshold_in, probe_out, driver_enable_out;
  logic [1:0] idle_detect_enable_out, squelch_out, s_axi_bresp_out, s_axi_rresp_out;
  logic standby_out, ch1_route_b_out, ch2_source_b_out, s_axi_awready_out, s_axi_wready_out;
  logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [5:0] deemph_code_out, equalize_code_out;
  logic [2:0] low_swing_out;
  logic [31:0] s_axi_rdata_out, rd;
  logic [3:0] s_axi_awaddr_in = 4'h0, s_axi_araddr_in = 4'h0, s_axi_wstrb_in = 4'hF;
  logic [31:0] s_axi_wdata_in = 32'h1;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  int miscompares = 0;
  int n_compared = 0;
  // Clock of 100 ns period.
  always #50 clk_in = ~clk_in;
  // Design with its straps taken from one vector.
  rmc_redriver_mux_control rmc_redriver_mux_control_inst (.*, .ch1_out_a_deemph_msb_in(st[11]),
    .ch1_out_a_deemph_lsb_in(st[10]), .ch1_out_b_deemph_msb_in(st[9]), .ch1_out_b_deemph_lsb_in(st[8]),
    .ch2_out_deemph_msb_in(st[7]), .ch2_out_deemph_lsb_in(st[6]), .ch1_in_equalize_msb_in(st[5]),
    .ch1_in_equalize_lsb_in(st[4]), .ch2_in_a_equalize_msb_in(st[3]), .ch2_in_a_equalize_lsb_in(st[2]),
    .ch2_in_b_equalize_msb_in(st[1]), .ch2_in_b_equalize_lsb_in(st[0]));
  // Far-end partners on both channels.
  rmc_link_partner rmc_link_partner_inst (.clk_in(clk_in), .att_in(att), .send_in(snd), .delay_in(dly),
    .probe_in(probe_out), .present_out(receiver_present_in), .above_out(above_idle_level_threshold_in));
  // Compares one value and counts it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Prints the counts and the verdict, then stops.
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  // A wait that ran out counts as a mismatch.
  task automatic bound(input int n);
    check(n < 3000, 1'b1);
    if (n >= 3000) tally_and_finish();
  endtask : bound
  // Expected equalization code of one strap pair.
  function automatic logic [1:0] eqf(input logic [1:0] s);
    return s[1] ? {s[0], !s[0]} : 2'h0;
  endfunction : eqf
  // Waits until standby shows the given level.
  task automatic wait_standby(input logic v);
    int n;
    for (n = 0; n < 3000 && standby_out !== v; n++) @(posedge clk_in);
    bound(n);
  endtask : wait_standby
  // One bus write or read; holds each valid until its ready.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [1:0] resp, output logic [31:0] q);
    int n;
    {s_axi_awaddr_in, s_axi_araddr_in} <= {a, a};
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= {3{wr}};
    {s_axi_arvalid_in, s_axi_rready_in} <= {2{!wr}};
    for (n = 0; n < 3000; n++) begin
      @(posedge clk_in);
      if (s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
      if (s_axi_arready_out === 1'b1) s_axi_arvalid_in <= 1'b0;
      if ((wr ? s_axi_bvalid_out : s_axi_rvalid_out) === 1'b1) break;
    end
    {s_axi_bready_in, s_axi_rready_in} <= 2'h0;
    q = s_axi_rdata_out;
    check(wr ? s_axi_bresp_out : s_axi_rresp_out, resp);
    bound(n);
    @(posedge clk_in);
  endtask : bus
  // Main sequence.
  initial begin
    void'($urandom(32'h5CD5));
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      st <= (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'($urandom);
      {ch1_output_choice_in, ch2_input_choice_in} <= 2'($urandom);
      repeat (5) @(posedge clk_in);
      check(deemph_code_out, {st[7:6], st[9:8], st[11:10]});
      check(equalize_code_out, {eqf(st[1:0]), eqf(st[3:2]), eqf(st[5:4])});
      check({ch2_source_b_out, ch1_route_b_out}, {ch2_input_choice_in, ch1_output_choice_in});
      check(standby_out, 1'b1);
      check(low_swing_out, {~|st[7:6], ~|st[9:8], ~|st[11:10]});
      if (i == 0) check(low_swing_out, 3'h7);
    end
    enable_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    check({standby_out, probe_out}, 3'h7);
    wait_standby(1'b0);
    repeat (2) @(posedge clk_in);
    check({idle_detect_enable_out, driver_enable_out}, 4'hF);
    check(squelch_out, 2'h2);
    for (int k = 0; k < 4; k++) begin
      dly <= 8'($urandom);
      snd <= 2'($urandom);
      case (k)
        1: ch1_output_choice_in <= ~ch1_output_choice_in;
        2: ch2_input_choice_in <= ~ch2_input_choice_in;
        default: detect_trigger_in <= ~detect_trigger_in;
      endcase
      repeat (6) @(posedge clk_in);
      check(standby_out, 1'b1);
      wait_standby(1'b0);
      repeat (6) @(posedge clk_in);
      check(squelch_out, 2'(~snd));
    end
    att <= 2'h1;
    bus(1'b1, 4'h0, 2'h0, rd);
    repeat (3500) @(posedge clk_in);
    bus(1'b0, 4'h4, 2'h0, rd);
    check({rd[5:4], rd[1:0], standby_out}, 5'hB);
    bus(1'b0, 4'h8, 2'h0, rd);
    check(rd, 32'h2);
    att <= 2'h0;
    detect_trigger_in <= ~detect_trigger_in;
    repeat (2500) @(posedge clk_in);
    bus(1'b0, 4'h4, 2'h0, rd);
    check({rd[5:4], rd[1:0]}, 4'h1);
    {att, s_axi_wdata_in} <= {2'h3, 32'h3};
    bus(1'b1, 4'h0, 2'h0, rd);
    repeat (1500) @(posedge clk_in);
    bus(1'b0, 4'h4, 2'h0, rd);
    check({rd[5:4], rd[1:0]}, 4'hD);
    bus(1'b1, 4'h4, 2'h2, rd);
    bus(1'b0, 4'h2, 2'h2, rd);
    check(rd, 32'h0);
    bus(1'b0, 4'hC, 2'h0, rd);
    check(rd[11:0], {eqf(st[1:0]), eqf(st[3:2]), eqf(st[5:4]), st[7:6], st[9:8], st[11:10]});
    enable_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    check({standby_out, driver_enable_out}, 3'h4);
    tally_and_finish();
  end
endmodule : rmc_redriver_mux_control_tb
`default_nettype wire
